// File: rtl/serial_line_code_encoder.sv
`timescale 1ns/1ps
`include "line_code_cfg.svh"
module serial_line_code_encoder
  import line_code_pkg::*;
#(
  parameter int TICK_DIV = `TICK_DIV_DFLT,
  parameter int DEPTH = `BUF_DEPTH_DFLT
) (
  input wire logic clk_sys, // 25 MHz system clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic in_valid, // Upstream bit valid
  input wire logic in_data, // Upstream data bit
  output logic in_ready, // Buffer can take a bit
  input wire code_cfg_t cfg, // Mode, pulse-width variant, polar form
  output line_t line, // Line drive to the driver
  output logic bit_taken // Pulse: a bit began on the line
);

  localparam int DIV_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [DIV_W-1:0] div_r;
  logic tick_r;
  logic [3:0] phase_r;
  logic [3:0] phase_nxt;
  logic cur_bit_r;
  logic bit_nxt;
  code_cfg_t cfg_r;
  code_cfg_t cfg_nxt;
  logic act_r;
  logic act_nxt;
  logic tog_r;
  logic tog_nxt;
  logic lvl_nxt;
  logic nrz_nxt;
  logic bnd;
  logic mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic push;
  logic pop;
  logic head;
  line_t line_r;
  logic in_ready_r;
  logic bit_taken_r;

  assign line = line_r;
  assign in_ready = in_ready_r;
  assign bit_taken = bit_taken_r;

  // Tick divider: twelve ticks make one bit period
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else if (div_r == DIV_W'(TICK_DIV - 1)) begin
      div_r <= '0;
      tick_r <= 1'b1;
    end else begin
      div_r <= div_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  assign bnd = tick_r && (phase_r == `PHASE_LAST);

  // Two-entry buffer between source and line; stalls never drop a bit
  assign push = in_valid && in_ready_r;
  assign pop = bnd && (cnt_r != '0);
  assign head = mem[rd_ptr_r];
  assign cnt_nxt = cnt_r + CNT_W'(push) - CNT_W'(pop);

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      in_ready_r <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      in_ready_r <= (cnt_nxt < CNT_W'(DEPTH));
    end
  end

  // Next bit state; a new bit and its mode are latched only at a boundary
  always_comb begin
    phase_nxt = phase_r;
    bit_nxt = cur_bit_r;
    cfg_nxt = cfg_r;
    act_nxt = act_r;
    if (tick_r) begin
      phase_nxt = (phase_r == `PHASE_LAST) ? `PHASE_FIRST : phase_r + 4'h1;
    end
    if (bnd) begin
      act_nxt = (cnt_r != '0);
      bit_nxt = head;
      cfg_nxt = cfg;
    end
  end

  // Toggle state for the mark/space families
  always_comb begin
    tog_nxt = tog_r;
    if (bnd && act_nxt) begin
      unique case (cfg_nxt.mode)
        MODE_MARK: tog_nxt = tog_r ^ bit_nxt;
        MODE_SPACE: tog_nxt = tog_r ^ ~bit_nxt;
        MODE_SPM, MODE_SPS: tog_nxt = ~tog_r;
        default: tog_nxt = tog_r;
      endcase
    end else if (tick_r && act_r && phase_nxt == `PHASE_HALF) begin
      unique case (cfg_r.mode)
        MODE_SPM: tog_nxt = tog_r ^ ~cur_bit_r;
        MODE_SPS: tog_nxt = tog_r ^ cur_bit_r;
        default: tog_nxt = tog_r;
      endcase
    end
  end

  // Line level from the upcoming phase; idle bits drive level low, but mark-toggle and space-toggle codes hold the toggle level
  always_comb begin
    lvl_nxt = `LINE_RST_LEVEL;
    nrz_nxt = 1'b0;
    unique case (cfg_nxt.mode)
      MODE_LEVEL: begin
        nrz_nxt = 1'b1;
        lvl_nxt = act_nxt && bit_nxt;
      end
      MODE_MARK, MODE_SPACE: begin
        nrz_nxt = 1'b1;
        lvl_nxt = tog_nxt;
      end
      MODE_RET_ZERO: begin
        lvl_nxt = act_nxt && bit_nxt && (phase_nxt < `PHASE_HALF);
      end
      MODE_PULSE_POS: begin
        if (bit_nxt) begin
          lvl_nxt = act_nxt && (phase_nxt >= `PHASE_HALF) && (phase_nxt < `PHASE_THREE_QUARTER);
        end else begin
          lvl_nxt = act_nxt && (phase_nxt < `PHASE_QUARTER);
        end
      end
      MODE_PW: begin
        if (cfg_nxt.pw_quarter) begin
          lvl_nxt = act_nxt && (phase_nxt < (bit_nxt ? `PHASE_THREE_QUARTER : `PHASE_QUARTER));
        end else begin
          lvl_nxt = act_nxt && (phase_nxt < (bit_nxt ? `PHASE_TWO_THIRD : `PHASE_THIRD));
        end
      end
      MODE_SPL: begin
        lvl_nxt = act_nxt && (bit_nxt ^ (phase_nxt >= `PHASE_HALF));
      end
      MODE_SPM, MODE_SPS: begin
        lvl_nxt = act_nxt && tog_nxt;
      end
      default: begin
        lvl_nxt = `LINE_RST_LEVEL;
      end
    endcase
  end

  // Phase and latched bit state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase_r <= `PHASE_LAST;
      cur_bit_r <= 1'b0;
      cfg_r <= '0;
      act_r <= 1'b0;
      tog_r <= `TOGGLE_RST;
    end else if (tick_r) begin
      phase_r <= phase_nxt;
      cur_bit_r <= bit_nxt;
      cfg_r <= cfg_nxt;
      act_r <= act_nxt;
      tog_r <= tog_nxt;
    end
  end

  // Registered line drive keeps every code free of decode glitches
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      line_r <= '0;
    end else if (tick_r) begin
      line_r.level <= lvl_nxt;
      line_r.polar <= cfg_nxt.polar && nrz_nxt;
      line_r.negative <= cfg_nxt.polar && nrz_nxt && !lvl_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bit_taken_r <= 1'b0;
    end else begin
      bit_taken_r <= pop;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  reset_state_a: assert property (disable iff (1'b0)
    rst |=> (line_r == '0) && (phase_r == `PHASE_LAST) && !tog_r && !act_r)
    else $error("reset did not quiet the line");

  bit_boundary_a: assert property (
    bnd |=> (phase_r == `PHASE_FIRST) && (bit_taken_r == ($past(cnt_r) != '0)))
    else $error("bit boundary timing wrong");

  taken_pulse_a: assert property (
    bit_taken_r |=> !bit_taken_r)
    else $error("bit taken pulse longer than one cycle");

  phase_step_a: assert property (
    (tick_r && phase_r != `PHASE_LAST) |=> phase_r == $past(phase_r) + 4'h1)
    else $error("phase did not advance by one");

  nrz_stable_a: assert property (
    (tick_r && phase_r != `PHASE_LAST && cfg_r.mode inside {MODE_LEVEL, MODE_MARK, MODE_SPACE})
    |=> $stable(line_r.level))
    else $error("non-return-to-zero level moved mid-bit");

  level_code_a: assert property (
    (act_r && cfg_r.mode == MODE_LEVEL) |-> line_r.level == cur_bit_r)
    else $error("level code does not follow data");

  mark_toggle_a: assert property (
    (bnd && cnt_r != '0 && cfg.mode == MODE_MARK) |=>
    (line_r.level != $past(line_r.level)) == $past(head))
    else $error("mark toggle wrong");

  space_toggle_a: assert property (
    (bnd && cnt_r != '0 && cfg.mode == MODE_SPACE) |=>
    (line_r.level != $past(line_r.level)) == !$past(head))
    else $error("space toggle wrong");

  rtz_pulse_a: assert property (
    (act_r && cfg_r.mode == MODE_RET_ZERO) |-> line_r.level == (cur_bit_r && phase_r < `PHASE_HALF))
    else $error("return-to-zero pulse wrong");

  pos_zero_a: assert property (
    (act_r && cfg_r.mode == MODE_PULSE_POS && !cur_bit_r) |-> line_r.level == (phase_r < `PHASE_QUARTER))
    else $error("pulse-position zero pulse wrong");

  pos_one_a: assert property (
    (act_r && cfg_r.mode == MODE_PULSE_POS && cur_bit_r) |->
    line_r.level == (phase_r >= `PHASE_HALF && phase_r < `PHASE_THREE_QUARTER))
    else $error("pulse-position one pulse wrong");

  pw_width_a: assert property (
    (act_r && cfg_r.mode == MODE_PW && !cfg_r.pw_quarter) |->
    line_r.level == (phase_r < (cur_bit_r ? `PHASE_TWO_THIRD : `PHASE_THIRD)))
    else $error("pulse-width length wrong");

  pw_quarter_a: assert property (
    (act_r && cfg_r.mode == MODE_PW && cfg_r.pw_quarter) |->
    line_r.level == (phase_r < (cur_bit_r ? `PHASE_THREE_QUARTER : `PHASE_QUARTER)))
    else $error("quarter pulse-width length wrong");

  pw_rise_a: assert property (
    (act_r && cfg_r.mode == MODE_PW && phase_r == `PHASE_FIRST) |-> line_r.level)
    else $error("pulse-width pulse not high at bit start");

  split_level_a: assert property (
    (act_r && cfg_r.mode == MODE_SPL) |-> line_r.level == (cur_bit_r ^ (phase_r >= `PHASE_HALF)))
    else $error("split-phase level polarity wrong");

  split_flip_a: assert property (
    (tick_r && act_r && phase_r == `PHASE_HALF - 4'h1 && cfg_r.mode == MODE_SPL)
    |=> line_r.level != $past(line_r.level))
    else $error("split-phase level mid-bit transition missing");

  split_edge_a: assert property (
    (bnd && cnt_r != '0 && act_r && cfg.mode == cfg_r.mode && cfg_r.mode inside {MODE_SPM, MODE_SPS})
    |=> line_r.level != $past(line_r.level))
    else $error("split-phase boundary transition missing");

  split_mid_a: assert property (
    (tick_r && act_r && phase_r == `PHASE_HALF - 4'h1 &&
     ((cfg_r.mode == MODE_SPM && !cur_bit_r) || (cfg_r.mode == MODE_SPS && cur_bit_r)))
    |=> line_r.level != $past(line_r.level))
    else $error("split-phase mid-bit transition missing");

  polar_sign_a: assert property (
    line_r.negative |-> (line_r.polar && !line_r.level))
    else $error("sign indication inconsistent");

  // Ready is held low through reset, so the cycle just after it is exempt
  buffer_count_a: assert property (
    !$past(rst) |-> (cnt_r <= CNT_W'(DEPTH)) && (in_ready_r == (cnt_r < CNT_W'(DEPTH))))
    else $error("buffer count or ready wrong");

endmodule

// File: rtl/line_code_cfg.svh
// Notes on behaviour
// - Level code holds one constant level per bit; high for One, low for Zero.
// - Mark-toggle code inverts the line at the start of each One bit.
// - Space-toggle code inverts the line at the start of each Zero bit.
// - Non-return-to-zero codes change level only at bit boundaries.
// - Return-to-zero is data AND bit clock: half-bit pulse for One, none for Zero.
// - Pulse-position Zero is a quarter-bit pulse at the start of the bit.
// - Pulse-position One is a quarter-bit pulse starting at mid-bit.
// - Pulse-width code sends one-third bit for Zero, two-thirds bit for One.
// - Every pulse-width pulse rises at the start of its bit period.
// - Optional quarter-based pulse-width variant; thirds remain the default.
// - Split-phase level is data XNOR bit clock.
// - Split-phase level comes from a registered output, so it is glitch free.
// - Split-phase mark holds level for One, mid-bit transition for Zero.
// - Split-phase space is split-phase mark with One and Zero swapped.
// - Split-phase codes give at least one transition in every active bit that follows an active bit of the same code.
// - Non-return-to-zero codes offer unipolar or polar output with a sign indication.
// - Split-phase mark and space invert the line at every boundary between two active bits of the same code.
// - Split-phase level: mid-bit rise means Zero, mid-bit fall means One.
`ifndef LINE_CODE_CFG_SVH
`define LINE_CODE_CFG_SVH

`define TICKS_PER_BIT 12
`define PHASE_LAST 4'hB
`define PHASE_FIRST 4'h0
`define PHASE_QUARTER 4'h3
`define PHASE_THIRD 4'h4
`define PHASE_HALF 4'h6
`define PHASE_TWO_THIRD 4'h8
`define PHASE_THREE_QUARTER 4'h9
`define TICK_DIV_DFLT 4
`define BUF_DEPTH_DFLT 2
`define LINE_RST_LEVEL 1'b0
`define TOGGLE_RST 1'b0

`endif

// File: rtl/line_code_pkg.sv
package line_code_pkg;

  typedef enum logic [3:0] {
    MODE_LEVEL = 4'h0,
    MODE_MARK = 4'h1,
    MODE_SPACE = 4'h2,
    MODE_RET_ZERO = 4'h3,
    MODE_PULSE_POS = 4'h4,
    MODE_PW = 4'h5,
    MODE_SPL = 4'h6,
    MODE_SPM = 4'h7,
    MODE_SPS = 4'h8
  } mode_t;

  typedef struct packed {
    logic polar;
    logic negative;
    logic level;
  } line_t;

  typedef struct packed {
    mode_t mode;
    logic pw_quarter;
    logic polar;
  } code_cfg_t;

endpackage

// File: verif/line_sink.sv
`timescale 1ns/1ps
module line_sink
  import line_code_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic rst, // Synchronous reset
  input wire line_t line, // Line from encoder
  input wire logic bit_taken, // Bit start marker
  output logic pat_valid, // Pulse: one bit captured
  output logic [13:0] pat // {polar, negative, 12 phase samples}
);
  logic [10:0] sh_r;
  logic [3:0] cnt_r;
  logic [1:0] sgn_r;
  // One sample a clock; only valid with a tick on every clock
  always_ff @(posedge clk_sys) begin
    pat_valid <= 1'b0;
    if (rst) begin
      cnt_r <= 4'h0;
    end else if (bit_taken) begin
      cnt_r <= 4'h1;
      sh_r <= {line.level, 10'h000};
      sgn_r <= {line.polar, line.negative};
    end else if (cnt_r != 4'h0) begin
      sh_r <= {line.level, sh_r[10:1]};
      cnt_r <= (cnt_r == 4'hB) ? 4'h0 : cnt_r + 4'h1;
      if (cnt_r == 4'hB) begin
        pat_valid <= 1'b1;
        pat <= {sgn_r, line.level, sh_r};
      end
    end
  end
endmodule

// File: verif/serial_line_code_encoder_tb.sv
`timescale 1ns/1ps
module serial_line_code_encoder_tb;
  import line_code_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic in_valid = 1'b0;
  logic in_data = 1'b0;
  code_cfg_t cfg = '0;
  logic in_ready;
  logic bit_taken;
  logic pat_valid;
  line_t line;
  logic [13:0] pat;
  logic [13:0] exp_q[$];
  logic [31:0] seed = 32'h11;
  logic lvl = 1'b0;
  logic full_seen = 1'b0;
  int bad_count = 0;
  int cmp_count = 0;

  always #20 clk_sys = ~clk_sys;

  serial_line_code_encoder #(.TICK_DIV(1), .DEPTH(2)) serial_line_code_encoder_i (
    .clk_sys(clk_sys), .rst(rst), .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .cfg(cfg), .line(line), .bit_taken(bit_taken));

  line_sink line_sink_i (.clk_sys(clk_sys), .rst(rst), .line(line), .bit_taken(bit_taken),
    .pat_valid(pat_valid), .pat(pat));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Expected twelve phase levels of one bit, from the current code
  task automatic note(input logic d);
    logic [11:0] p12;
    logic v;
    logic pol;
    for (int p = 0; p < 12; p++) begin
      case (cfg.mode)
        MODE_LEVEL: v = d;
        MODE_MARK: v = lvl ^ d;
        MODE_SPACE: v = lvl ^ ~d;
        MODE_RET_ZERO: v = d && p < 6;
        MODE_PULSE_POS: v = d ? (p >= 6 && p < 9) : p < 3;
        MODE_PW: v = d ? p < (cfg.pw_quarter ? 9 : 8) : p < (cfg.pw_quarter ? 3 : 4);
        MODE_SPL: v = d ^ (p >= 6);
        MODE_SPM: v = (p < 6) ? ~lvl : (lvl ^ d);
        MODE_SPS: v = (p < 6) ? ~lvl : (lvl ^ ~d);
        default: v = 1'b0;
      endcase
      p12[p] = v;
    end
    lvl = p12[11];
    pol = cfg.polar && (cfg.mode inside {MODE_LEVEL, MODE_MARK, MODE_SPACE});
    exp_q.push_back({pol, pol & ~p12[0], p12});
  endtask

  // Holds the bit until the edge where in_ready is high; in_valid stays up
  task automatic send(input logic d);
    int n;
    n = 0;
    in_valid = 1'b1;
    in_data = d;
    note(d);
    while (in_ready !== 1'b1) begin
      n++;
      if (n > 2) begin
        full_seen = 1'b1; // Only a full buffer stalls this long
      end
      if (n > 100) begin
        bad_count++;
        end_sim();
      end
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    #1;
  endtask

  always @(posedge clk_sys) begin
    if (pat_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("mismatch at %0t: seen %h expected %h", $time, pat, 14'h0000);
      end else begin
        chk(pat, exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    bad_count++;
    end_sim();
  end

  initial begin
    int n;
    for (int i = 0; i < 11; i++) begin
      rst = 1'b1;
      cfg.mode = (i == 10) ? MODE_PW : mode_t'(i[3:0]);
      cfg.pw_quarter = (i == 10);
      seed = xs(seed);
      cfg.polar = (i < 3) ? i[0] : seed[0]; // Both NRZ forms always seen
      lvl = 1'b0;
      repeat (6) @(posedge clk_sys);
      #1;
      chk({9'h000, line, in_ready, bit_taken}, 14'h0000);
      rst = 1'b0;
      for (int j = 0; j < 8; j++) begin
        seed = xs(seed);
        send(seed[3]);
      end
      in_valid = 1'b0;
      n = 0;
      while (exp_q.size() > 0) begin
        n++;
        if (n > 200) begin
          bad_count++;
          end_sim();
        end
        @(posedge clk_sys);
        #1;
      end
      $display("test %0d done", i);
    end
    chk({13'h0000, full_seen}, 14'h0001);
    end_sim();
  end
endmodule
